/* rtl/ebrg_drv.sv */
// Registered three-state driver for address, data and memory strobes.
`timescale 1ns/10ps
`default_nettype none
module ebrg_drv #(
  parameter int ADDR_W = ebrg_pkg::ADDR_W,
  parameter int DATA_W = ebrg_pkg::DATA_W
) (
  input wire logic clk,
  ebrg_mem_if.pins mem,
  input wire logic [DATA_W-1:0] data_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  output logic [ebrg_pkg::STROBE_COUNT-1:0] strobe_n_o,
  output logic [ebrg_pkg::STROBE_COUNT-1:0] strobe_oe
);

  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [ebrg_pkg::STROBE_COUNT-1:0] strobe_n_ff;
  logic drive_ff;
  logic data_en_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [DATA_W-1:0] nxt_data;
  logic [DATA_W-1:0] nxt_rdata;
  logic [ebrg_pkg::STROBE_COUNT-1:0] nxt_strobe_n;
  logic nxt_drive;
  logic nxt_data_en;

  ////////////////////////////////////////////////////////////////////////////
  // Floated pins keep idle strobe levels so a release comes back inactive.
  always_comb
  begin
    nxt_drive = mem.drive;
    nxt_addr = mem.addr;
    nxt_data = mem.wdata;
    nxt_data_en = mem.drive & mem.wdata_en;
    nxt_strobe_n = mem.drive ? mem.strobe_n : ebrg_pkg::STROBE_IDLE_N;
    nxt_rdata = data_i;
  end

  always_ff @(posedge clk)
  begin
    drive_ff <= nxt_drive;
    addr_ff <= nxt_addr;
    data_ff <= nxt_data;
    data_en_ff <= nxt_data_en;
    strobe_n_ff <= nxt_strobe_n;
    rdata_ff <= nxt_rdata;
  end

  assign addr_o = addr_ff;
  assign addr_oe = drive_ff;
  assign data_o = data_ff;
  assign data_oe = data_en_ff;
  assign strobe_n_o = strobe_n_ff;
  assign strobe_oe = {ebrg_pkg::STROBE_COUNT{drive_ff}};
  assign mem.rdata = rdata_ff;

endmodule : ebrg_drv
`default_nettype wire

/* rtl/ebrg_mem_if.sv */
// Memory interface signals passed between the arbiter top and the pin driver.
`timescale 1ns/10ps
`default_nettype none
interface ebrg_mem_if #(
  parameter int ADDR_W = ebrg_pkg::ADDR_W,
  parameter int DATA_W = ebrg_pkg::DATA_W
);
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wdata_en;
  logic [DATA_W-1:0] rdata;
  logic [ebrg_pkg::STROBE_COUNT-1:0] strobe_n;
  logic drive;

  modport core (
    output addr,
    output wdata,
    output wdata_en,
    output strobe_n,
    output drive,
    input rdata
  );

  modport pins (
    input addr,
    input wdata,
    input wdata_en,
    input strobe_n,
    input drive,
    output rdata
  );
endinterface : ebrg_mem_if
`default_nettype wire

/* rtl/ebrg_pkg.sv */
// Constants and types for the external bus request and grant block.
package ebrg_pkg;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 24;
  localparam int SYNC_STAGES = 2;
  localparam int STROBE_COUNT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe positions inside the packed strobe vector.
  localparam int STB_PROGRAM = 0;
  localparam int STB_DATA = 1;
  localparam int STB_BYTE = 2;
  localparam int STB_COMPOSITE = 3;
  localparam int STB_IO = 4;
  localparam int STB_READ = 5;
  localparam int STB_WRITE = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the registered outputs.
  localparam logic GRANT_RST = 1'h0;
  localparam logic HUNG_RST = 1'h0;
  localparam logic DRIVE_RST = 1'h1;
  localparam logic [STROBE_COUNT-1:0] STROBE_IDLE_N = 7'h7f;

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter states.
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_GRANT = 2'b10,
    ST_HUNG = 2'b11
  } ebrg_state_t;

endpackage : ebrg_pkg

/* rtl/ebrg_sync.sv */
// Multi-stage synchroniser for an asynchronous level input.
`timescale 1ns/10ps
`default_nettype none
module ebrg_sync #(
  parameter int STAGES = ebrg_pkg::SYNC_STAGES
) (
  input wire logic clk,
  input wire logic d,
  output logic q
);

  logic [STAGES-1:0] stage_ff;
  logic [STAGES-1:0] nxt_stage;

  generate
    if (STAGES < 2)
    begin : g_check
      $error("ebrg_sync needs at least two stages.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // The stages run free so that the request is seen during reset as well.
  always_comb
  begin
    nxt_stage = {stage_ff[STAGES-2:0], d};
  end

  always_ff @(posedge clk)
  begin
    stage_ff <= nxt_stage;
  end

  assign q = stage_ff[STAGES-1];

endmodule : ebrg_sync
`default_nettype wire

/* rtl/ebrg_top.sv */
// External bus request and grant arbiter with emulator pin substitution.
//
// Summary of operation
// - Idle bus request grants next cycle, halts.
// - Granted: address, data, strobes float.
// - Run-ahead mode halts only at external access.
// - Request during access waits until after completion.
// - Grant may fall between two accesses.
// - Request release drops grant, drives, resumes.
// - Arbitration works during reset and booting.
// - Hung output flags stall on granted bus.
// - On return, drop grant, hung, then access.
// - Emulator enable swaps pins, floats normal grant.
// - Emulation ignores reset, request when stepping, halted.
`timescale 1ns/10ps
`default_nettype none
module ebrg_top #(
  parameter int ADDR_W = ebrg_pkg::ADDR_W,
  parameter int DATA_W = ebrg_pkg::DATA_W
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic BUS_REQUEST_N,
  output logic BUS_GRANT_N,
  output logic BUS_GRANT_N_OE,
  output logic GRANT_HUNG_N,
  input wire logic EMULATOR_ENABLE,
  input wire logic EMULATOR_RESET_N,
  input wire logic EMULATOR_BUS_REQUEST_N,
  output logic EMULATOR_BUS_GRANT_N,
  input wire logic EMU_SINGLE_STEP,
  input wire logic EMU_HALTED,
  input wire logic GO_MODE,
  input wire logic CORE_READY,
  input wire logic CORE_NEED_EXT,
  input wire logic CORE_EXT_ACCESS,
  input wire logic CORE_EXT_DONE,
  input wire logic [ADDR_W-1:0] CORE_ADDR,
  input wire logic [DATA_W-1:0] CORE_WDATA,
  input wire logic CORE_WRITE_EN,
  input wire logic [ebrg_pkg::STROBE_COUNT-1:0] CORE_STROBE_N,
  output logic [DATA_W-1:0] CORE_RDATA,
  output logic CORE_HALT,
  output logic CORE_RESET_N,
  output logic [ADDR_W-1:0] ADDR_O,
  output logic ADDR_OE,
  input wire logic [DATA_W-1:0] DATA_I,
  output logic [DATA_W-1:0] DATA_O,
  output logic DATA_OE,
  output logic PROGRAM_MEM_SELECT_N,
  output logic PROGRAM_MEM_SELECT_N_OE,
  output logic DATA_MEM_SELECT_N,
  output logic DATA_MEM_SELECT_N_OE,
  output logic BYTE_MEM_SELECT_N,
  output logic BYTE_MEM_SELECT_N_OE,
  output logic COMPOSITE_MEM_SELECT_N,
  output logic COMPOSITE_MEM_SELECT_N_OE,
  output logic IO_SPACE_SELECT_N,
  output logic IO_SPACE_SELECT_N_OE,
  output logic READ_STROBE_N,
  output logic READ_STROBE_N_OE,
  output logic WRITE_STROBE_N,
  output logic WRITE_STROBE_N_OE
);

  generate
    if (ADDR_W < 1 || DATA_W < 1)
    begin : g_check
      $error("ebrg_top needs positive address and data widths.");
    end
  endgenerate

  ebrg_pkg::ebrg_state_t state_ff;
  ebrg_pkg::ebrg_state_t nxt_state;
  logic granted_ff;
  logic hung_ff;
  logic grant_n_ff;
  logic grant_oe_ff;
  logic emu_grant_n_ff;
  logic nxt_granted;
  logic nxt_hung;
  logic nxt_grant_n;
  logic nxt_grant_oe;
  logic nxt_emu_grant_n;
  logic req_pin_n;
  logic req_sync_n;
  logic ignore_target;
  logic req_act;
  logic blk_rst_n;
  logic stall_need;
  logic [ebrg_pkg::STROBE_COUNT-1:0] strobe_n;
  logic [ebrg_pkg::STROBE_COUNT-1:0] strobe_oe;

  ebrg_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mem ();

  ////////////////////////////////////////////////////////////////////////////
  // Request source selection and synchronisation.
  assign req_pin_n = EMULATOR_ENABLE ? EMULATOR_BUS_REQUEST_N : BUS_REQUEST_N;

  ebrg_sync #(.STAGES(ebrg_pkg::SYNC_STAGES)) u_req_sync (
    .clk(CLK),
    .d(req_pin_n),
    .q(req_sync_n)
  );

  assign ignore_target = EMULATOR_ENABLE & (EMU_SINGLE_STEP | EMU_HALTED);
  assign req_act = ignore_target ? granted_ff : ~req_sync_n;

  always_comb
  begin
    if (EMULATOR_ENABLE)
    begin
      blk_rst_n = ignore_target | EMULATOR_RESET_N;
    end
    else
    begin
      blk_rst_n = RESET_N;
    end
  end

  assign CORE_RESET_N = blk_rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter state machine.
  assign stall_need = ~GO_MODE | CORE_NEED_EXT;

  always_comb
  begin
    nxt_state = state_ff;
    if (!blk_rst_n)
    begin
      // Nothing is accessed in reset, so a request is granted at once.
      nxt_state = req_act ? ebrg_pkg::ST_GRANT : ebrg_pkg::ST_RUN;
    end
    else
    begin
      case (state_ff)
        ebrg_pkg::ST_RUN:
        begin
          if (req_act)
          begin
            if (CORE_EXT_ACCESS && !CORE_EXT_DONE)
            begin
              nxt_state = ebrg_pkg::ST_WAIT;
            end
            else
            begin
              nxt_state = ebrg_pkg::ST_GRANT;
            end
          end
        end
        ebrg_pkg::ST_WAIT:
        begin
          if (!req_act)
          begin
            nxt_state = ebrg_pkg::ST_RUN;
          end
          else if (CORE_EXT_DONE)
          begin
            nxt_state = ebrg_pkg::ST_GRANT;
          end
        end
        ebrg_pkg::ST_GRANT:
        begin
          if (!req_act)
          begin
            nxt_state = ebrg_pkg::ST_RUN;
          end
          else if (CORE_READY && stall_need)
          begin
            nxt_state = ebrg_pkg::ST_HUNG;
          end
        end
        ebrg_pkg::ST_HUNG:
        begin
          if (!req_act)
          begin
            nxt_state = ebrg_pkg::ST_RUN;
          end
        end
        default:
        begin
          nxt_state = ebrg_pkg::ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered grant and hung outputs follow the next state; the grant enable follows the inverse of EMULATOR_ENABLE.
  always_comb
  begin
    nxt_granted = (nxt_state == ebrg_pkg::ST_GRANT) || (nxt_state == ebrg_pkg::ST_HUNG);
    nxt_hung = (nxt_state == ebrg_pkg::ST_HUNG);
    nxt_grant_n = ~(nxt_granted & ~EMULATOR_ENABLE);
    nxt_grant_oe = ~EMULATOR_ENABLE;
    nxt_emu_grant_n = ~(nxt_granted & EMULATOR_ENABLE);
  end

  always_ff @(posedge CLK)
  begin
    state_ff <= nxt_state;
    granted_ff <= nxt_granted;
    hung_ff <= nxt_hung;
    grant_n_ff <= nxt_grant_n;
    grant_oe_ff <= nxt_grant_oe;
    emu_grant_n_ff <= nxt_emu_grant_n;
  end

  assign BUS_GRANT_N = grant_n_ff;
  assign BUS_GRANT_N_OE = grant_oe_ff;
  assign EMULATOR_BUS_GRANT_N = emu_grant_n_ff;
  assign GRANT_HUNG_N = ~hung_ff;

  // Halt is held while the bus is away and the core may not run ahead.
  assign CORE_HALT = (state_ff == ebrg_pkg::ST_HUNG) ||
                     ((state_ff == ebrg_pkg::ST_GRANT) && stall_need);

  ////////////////////////////////////////////////////////////////////////////
  // Memory pins, floated together with the grant edge.
  assign mem.addr = CORE_ADDR;
  assign mem.wdata = CORE_WDATA;
  assign mem.wdata_en = CORE_WRITE_EN;
  assign mem.strobe_n = CORE_STROBE_N;
  assign mem.drive = ~nxt_granted;
  assign CORE_RDATA = mem.rdata;

  ebrg_drv #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_drv (
    .clk(CLK),
    .mem(mem),
    .data_i(DATA_I),
    .addr_o(ADDR_O),
    .addr_oe(ADDR_OE),
    .data_o(DATA_O),
    .data_oe(DATA_OE),
    .strobe_n_o(strobe_n),
    .strobe_oe(strobe_oe)
  );

  assign PROGRAM_MEM_SELECT_N = strobe_n[ebrg_pkg::STB_PROGRAM];
  assign PROGRAM_MEM_SELECT_N_OE = strobe_oe[ebrg_pkg::STB_PROGRAM];
  assign DATA_MEM_SELECT_N = strobe_n[ebrg_pkg::STB_DATA];
  assign DATA_MEM_SELECT_N_OE = strobe_oe[ebrg_pkg::STB_DATA];
  assign BYTE_MEM_SELECT_N = strobe_n[ebrg_pkg::STB_BYTE];
  assign BYTE_MEM_SELECT_N_OE = strobe_oe[ebrg_pkg::STB_BYTE];
  assign COMPOSITE_MEM_SELECT_N = strobe_n[ebrg_pkg::STB_COMPOSITE];
  assign COMPOSITE_MEM_SELECT_N_OE = strobe_oe[ebrg_pkg::STB_COMPOSITE];
  assign IO_SPACE_SELECT_N = strobe_n[ebrg_pkg::STB_IO];
  assign IO_SPACE_SELECT_N_OE = strobe_oe[ebrg_pkg::STB_IO];
  assign READ_STROBE_N = strobe_n[ebrg_pkg::STB_READ];
  assign READ_STROBE_N_OE = strobe_oe[ebrg_pkg::STB_READ];
  assign WRITE_STROBE_N = strobe_n[ebrg_pkg::STB_WRITE];
  assign WRITE_STROBE_N_OE = strobe_oe[ebrg_pkg::STB_WRITE];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.
  default clocking cb @(posedge CLK);
  endclocking

  idle_grant_a: assert property (disable iff (!blk_rst_n)
    (state_ff == ebrg_pkg::ST_RUN && req_act && !CORE_EXT_ACCESS && !GO_MODE)
    |=> (granted_ff && CORE_HALT && !ADDR_OE))
    else $error("Idle request not granted with halt in the next cycle.");

  float_when_granted_a: assert property (disable iff (!blk_rst_n)
    granted_ff |-> (!ADDR_OE && !DATA_OE && strobe_oe == '0))
    else $error("Memory pins driven while the bus is granted.");

  run_ahead_a: assert property (disable iff (!blk_rst_n)
    (state_ff == ebrg_pkg::ST_GRANT && GO_MODE && !CORE_NEED_EXT) |-> !CORE_HALT)
    else $error("Core halted in run-ahead mode without external access.");

  access_holds_a: assert property (disable iff (!blk_rst_n)
    (CORE_EXT_ACCESS && !CORE_EXT_DONE && !granted_ff) |=> !granted_ff)
    else $error("Bus granted before the external access completed.");

  between_access_a: assert property (disable iff (!blk_rst_n)
    (state_ff == ebrg_pkg::ST_WAIT && CORE_EXT_DONE && req_act) |=> (granted_ff && !ADDR_OE))
    else $error("Bus not granted after the access completed.");

  release_resume_a: assert property (disable iff (!blk_rst_n)
    (granted_ff && !req_act) |=> (!granted_ff && !CORE_HALT && ADDR_OE))
    else $error("Release did not restore drivers and execution.");

  reset_grant_a: assert property (
    (!blk_rst_n && req_act) |=> granted_ff)
    else $error("Request not granted while reset is active.");

  hung_flag_a: assert property (disable iff (!blk_rst_n)
    (state_ff == ebrg_pkg::ST_GRANT && req_act && CORE_READY && stall_need)
    |=> (!GRANT_HUNG_N && CORE_HALT))
    else $error("Stalled core did not raise the hung flag.");

  hung_return_a: assert property (disable iff (!blk_rst_n)
    (hung_ff && !req_act) |=> (GRANT_HUNG_N && !granted_ff && !CORE_HALT))
    else $error("Return of the bus did not clear grant and hung.");

  emu_grant_a: assert property (disable iff (!blk_rst_n)
    (EMULATOR_ENABLE && $past(EMULATOR_ENABLE)) |-> (!BUS_GRANT_N_OE &&
    (EMULATOR_BUS_GRANT_N == !granted_ff)))
    else $error("Emulator grant pins not substituted.");

  emu_ignore_a: assert property (
    ignore_target |-> CORE_RESET_N ##1 (granted_ff == $past(granted_ff)))
    else $error("Target request acted on while emulation ignores it.");

  req_sync_a: assert property (disable iff (!blk_rst_n)
    (!EMULATOR_ENABLE && $past(EMULATOR_ENABLE) == 1'h0 && $past(EMULATOR_ENABLE, 2) == 1'h0)
    |-> (req_sync_n == $past(BUS_REQUEST_N, 2)))
    else $error("Request synchroniser latency is wrong.");

  grant_cv: cover property (disable iff (!blk_rst_n)
    (state_ff == ebrg_pkg::ST_RUN) ##1 granted_ff ##[1:20] !granted_ff);

  hung_cv: cover property (disable iff (!blk_rst_n)
    hung_ff ##1 !hung_ff);

  wait_cv: cover property (disable iff (!blk_rst_n)
    (state_ff == ebrg_pkg::ST_WAIT) ##[1:10] (state_ff == ebrg_pkg::ST_GRANT));

  emu_cv: cover property (disable iff (!blk_rst_n)
    EMULATOR_ENABLE && !EMULATOR_BUS_GRANT_N);

endmodule : ebrg_top
`default_nettype wire

/* sim/ebrg_master_model.sv */
// Behavioural model of the outside master that borrows the memory bus.
`timescale 1ns/10ps
`default_nettype none
module ebrg_master_model (
  input wire logic want,
  input wire logic bus_grant_n,
  output logic bus_request_n,
  output logic owns_bus
);
  // The request is a level that only falls back when the bench withdraws it.
  assign bus_request_n = ~want;
  // The bus counts as taken only while the grant is really low.
  assign owns_bus = want & (bus_grant_n == 1'h0);
endmodule : ebrg_master_model
`default_nettype wire

/* sim/ebrg_tb_top.sv */
// Self-checking bench for the external bus request and grant arbiter.
`timescale 1ns/10ps
`default_nettype none
module ebrg_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic want = 1'b0;
  logic emu_en = 1'b0, emu_rst_n = 1'b1, emu_req_n = 1'b1, step = 1'b0, halted = 1'b0;
  logic go = 1'b0, ready = 1'b0, need = 1'b0, acc = 1'b0, done = 1'b0, wen = 1'b1;
  logic [ebrg_pkg::ADDR_W-1:0] core_addr = 14'h0000;
  logic [ebrg_pkg::ADDR_W-1:0] addr_o;
  logic bus_request_n, bus_grant_n, grant_oe, hung_n, emu_gnt_n, owns_bus, core_halt, core_rst_n;
  logic a_oe, d_oe, p_oe, dm_oe, b_oe, c_oe, io_oe, rd_oe, wr_oe;
  logic [8:0] all_oe;
  int errors = 0;
  int n_tests = 0;
  int n;

  assign all_oe = {a_oe, d_oe, p_oe, dm_oe, b_oe, c_oe, io_oe, rd_oe, wr_oe};

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  ebrg_master_model ebrg_master_model_inst (.want(want), .bus_grant_n(bus_grant_n),
    .bus_request_n(bus_request_n), .owns_bus(owns_bus));

  ebrg_top ebrg_top_inst (.CLK(clk), .RESET_N(reset_n), .BUS_REQUEST_N(bus_request_n),
    .BUS_GRANT_N(bus_grant_n), .BUS_GRANT_N_OE(grant_oe), .GRANT_HUNG_N(hung_n),
    .EMULATOR_ENABLE(emu_en), .EMULATOR_RESET_N(emu_rst_n),
    .EMULATOR_BUS_REQUEST_N(emu_req_n), .EMULATOR_BUS_GRANT_N(emu_gnt_n),
    .EMU_SINGLE_STEP(step), .EMU_HALTED(halted), .GO_MODE(go), .CORE_READY(ready),
    .CORE_NEED_EXT(need), .CORE_EXT_ACCESS(acc), .CORE_EXT_DONE(done),
    .CORE_ADDR(core_addr), .CORE_WDATA(24'h5a5a5a), .CORE_WRITE_EN(wen),
    .CORE_STROBE_N(7'h7f), .CORE_RDATA(), .CORE_HALT(core_halt), .CORE_RESET_N(core_rst_n),
    .ADDR_O(addr_o), .ADDR_OE(a_oe), .DATA_I(24'h000000), .DATA_O(), .DATA_OE(d_oe),
    .PROGRAM_MEM_SELECT_N(), .PROGRAM_MEM_SELECT_N_OE(p_oe),
    .DATA_MEM_SELECT_N(), .DATA_MEM_SELECT_N_OE(dm_oe),
    .BYTE_MEM_SELECT_N(), .BYTE_MEM_SELECT_N_OE(b_oe),
    .COMPOSITE_MEM_SELECT_N(), .COMPOSITE_MEM_SELECT_N_OE(c_oe),
    .IO_SPACE_SELECT_N(), .IO_SPACE_SELECT_N_OE(io_oe),
    .READ_STROBE_N(), .READ_STROBE_N_OE(rd_oe),
    .WRITE_STROBE_N(), .WRITE_STROBE_N_OE(wr_oe));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step_n(input int cnt);
    repeat (cnt) @(posedge clk);
    #1;
  endtask : step_n

  // Counts edges until the chosen grant line reaches the wanted level.
  task automatic wait_lvl(input logic emu, input logic lvl, output int cnt);
    cnt = 0;
    while (((emu ? emu_gnt_n : bus_grant_n) !== lvl) && (cnt < 10))
    begin
      step_n(1);
      cnt++;
    end
  endtask : wait_lvl

  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if ((errors == 0) && (n_tests > 0))
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_req;
    step_n(3);
    chk({bus_grant_n, hung_n, core_halt}, 3'h6);
    want = 1'b1;
    wait_lvl(1'b0, 1'b0, n);
    chk((n >= 3) && (n <= 4), 1'h1);
    chk(all_oe, 9'h000);
    want = 1'b0;
    wait_lvl(1'b0, 1'b1, n);
    chk({(n >= 3) && (n <= 4), core_rst_n}, 2'h2);
    $display("done: request during reset");
  endtask : t_reset_req

  task automatic t_idle_grant;
    ready = 1'b1;
    want = 1'b1;
    wait_lvl(1'b0, 1'b0, n);
    chk((n >= 3) && (n <= 4), 1'h1);
    chk({core_halt, owns_bus}, 2'h3);
    chk(all_oe, 9'h000);
    step_n(1);
    chk(hung_n, 1'h0);
    want = 1'b0;
    wait_lvl(1'b0, 1'b1, n);
    chk((n >= 3) && (n <= 4), 1'h1);
    chk(hung_n, 1'h1);
    chk({all_oe, core_halt}, 10'h3fe);
    $display("done: idle grant and return");
  endtask : t_idle_grant

  task automatic t_during_access;
    acc = 1'b1;
    wen = 1'b0;
    core_addr = 14'h1a5;
    want = 1'b1;
    step_n(6);
    chk({bus_grant_n, all_oe}, 10'h37f);
    done = 1'b1;
    step_n(1);
    done = 1'b0;
    acc = 1'b0;
    wen = 1'b1;
    wait_lvl(1'b0, 1'b0, n);
    chk(n, 32'h0);
    chk(all_oe, 9'h000);
    want = 1'b0;
    wait_lvl(1'b0, 1'b1, n);
    chk(all_oe, 9'h1ff);
    chk(addr_o, 14'h1a5);
    $display("done: request during access");
  endtask : t_during_access

  task automatic t_go_mode;
    go = 1'b1;
    want = 1'b1;
    wait_lvl(1'b0, 1'b0, n);
    step_n(1);
    chk({core_halt, hung_n}, 2'h1);
    need = 1'b1;
    #1;
    chk(core_halt, 1'h1);
    step_n(1);
    chk(hung_n, 1'h0);
    want = 1'b0;
    wait_lvl(1'b0, 1'b1, n);
    chk({hung_n, core_halt}, 2'h2);
    go = 1'b0;
    need = 1'b0;
    $display("done: run-ahead mode");
  endtask : t_go_mode

  task automatic t_emulator;
    emu_en = 1'b1;
    step_n(2);
    chk({grant_oe, emu_gnt_n}, 2'h1);
    reset_n = 1'b0;
    want = 1'b1;
    step_n(5);
    chk({core_rst_n, emu_gnt_n, grant_oe, owns_bus}, 4'hc);
    reset_n = 1'b1;
    want = 1'b0;
    emu_req_n = 1'b0;
    wait_lvl(1'b1, 1'b0, n);
    chk((n >= 3) && (n <= 4), 1'h1);
    chk(all_oe, 9'h000);
    halted = 1'b1;
    emu_req_n = 1'b1;
    step_n(5);
    chk(emu_gnt_n, 1'h0);
    halted = 1'b0;
    step = 1'b1;
    emu_rst_n = 1'b0;
    step_n(1);
    chk({core_rst_n, emu_gnt_n}, 2'h2);
    emu_rst_n = 1'b1;
    step = 1'b0;
    wait_lvl(1'b1, 1'b1, n);
    chk({emu_gnt_n, all_oe}, 10'h3ff);
    emu_en = 1'b0;
    step_n(2);
    chk({grant_oe, bus_grant_n}, 2'h3);
    $display("done: emulator pins");
  endtask : t_emulator

  ////////////////////////////////////////////////////////////////////////////
  // Reset is held for the first twelve cycles.
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
  end

  initial
  begin
    t_reset_req();
    step_n(4);
    t_idle_grant();
    t_during_access();
    t_go_mode();
    t_emulator();
    final_report();
  end

  // Stops a hung run long after the tests should have ended.
  initial
  begin
    #(3000 * 25);
    errors++;
    final_report();
  end
endmodule : ebrg_tb_top
`default_nettype wire
